// ### design/async_desc_engine.sv
// Execution state of one asynchronous (control or bulk) transfer descriptor.
// Assumes software presents the descriptor fields with a launch strobe and
// the bus engine reports each transaction outcome as a one-cycle pulse.
//
// Behaviour
// R1: two-bit retry counter, decremented per failed attempt
// R2: software keeps retry counter zero for isochronous
// R3: NAK counter loaded at launch, then hardware-updated
// R4: NAK count hits zero, reload nonzero: clear valid
// R5: acknowledged transaction restores NAK count from reload
// R6: reload zero disables NAK counting entirely
// R7: software writes reload and NAK count equal
// R8: record bytes moved; software may write it
// R9: partial byte counts stored between multiplied packets
// R10: payload offset is word address of CPU address
// R11: software zeroes reserved descriptor bits
// R12: split bit selects split or high-speed transaction
// R13: transfer kind 00 control, 10 bulk
// R14: token 00 OUT, 01 IN, 10 SETUP, 11 PING
// R15: transaction targets seven-bit function address
// R16: endpoint upper three bits join lowest bit
// R17: clear valid on completion or fatal error
// R18: PID error sets error, clears active, valid
// R19: multiplier bounds packets per execution; 00 undefined
// R20: bytes done equal requested: clear active, valid
`timescale 1ns/100ps
module async_desc_engine #(
    parameter int BYTES_W = async_desc_pkg::BYTES_W
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic launch_i,
    input wire logic [1:0] err_count_init_i,
    input wire logic [3:0] nak_retry_count_init_i,
    input wire logic [3:0] nak_reload_value_i,
    input wire logic [BYTES_W-1:0] bytes_requested_count_i,
    input wire logic [15:0] payload_buffer_offset_i,
    input wire logic split_sel_i,
    input wire logic [1:0] transfer_kind_i,
    input wire logic [1:0] token_code_i,
    input wire logic [6:0] target_function_addr_i,
    input wire logic [2:0] endpoint_hi_i,
    input wire logic endpoint_lo_i,
    input wire logic [1:0] mult_i,
    input wire logic bytes_wr_i,
    input wire logic [BYTES_W-1:0] bytes_wr_data_i,
    input wire logic ping_enter_i,
    input wire logic xact_ack_i,
    input wire logic [10:0] xact_bytes_i,
    input wire logic xact_nak_i,
    input wire logic xact_fail_i,
    input wire logic pid_err_i,
    output logic valid_o,
    output logic active_o,
    output logic xact_err_o,
    output logic launch_refused_o,
    output logic done_o,
    output logic exec_end_o,
    output logic [1:0] err_count_o,
    output logic [3:0] nak_retry_count_o,
    output logic [BYTES_W-1:0] bytes_done_count_o,
    output logic split_o,
    output logic [1:0] transfer_kind_o,
    output logic [1:0] token_code_o,
    output logic [6:0] target_function_addr_o,
    output logic [3:0] target_endpoint_number_o,
    output logic [15:0] payload_buffer_offset_o,
    output logic [19:0] payload_cpu_addr_o
);
    // Refuse widths that the byte adder or the progress field cannot serve
    if (BYTES_W < async_desc_pkg::PKT_LEN_W || BYTES_W > async_desc_pkg::BYTES_W)
    begin : g_bad_width
        $error("BYTES_W must lie between packet length width and 15");
    end

    async_desc_pkg::desc_state_t state_q, state_d;
    logic [3:0] reload_q, reload_d;
    logic [BYTES_W-1:0] req_q, req_d;
    logic [1:0] mult_q, mult_d;
    logic [1:0] pkt_q, pkt_d;
    logic [BYTES_W-1:0] bytes_d;
    logic valid_d, active_d, xerr_d, refused_d, done_d, exec_end_d;
    logic split_d;
    logic [1:0] kind_d, token_d;
    logic [6:0] faddr_d;
    logic [3:0] ep_d;
    logic [15:0] offset_d;
    logic [19:0] cpu_addr_d;
    logic launch_ok, running, ack_g, nak_g, fail_g, pid_g;
    logic nak_expired, retry_exhausted;
    logic [BYTES_W:0] bytes_sum;

    // Only well-formed descriptors start; PING is never accepted from software
    assign launch_ok = launch_i && mult_i != async_desc_pkg::MULT_UNDEFINED // R19
        && (transfer_kind_i == async_desc_pkg::KIND_CONTROL
        || transfer_kind_i == async_desc_pkg::KIND_BULK) // R13
        && token_code_i != async_desc_pkg::TOKEN_PING; // R14
    assign running = state_q == async_desc_pkg::ST_RUN && valid_o;
    // Outcomes outside a running descriptor are dropped; ack beats NAK beats fail, but a PID error is not gated against them
    assign ack_g = running && xact_ack_i;
    assign nak_g = running && !xact_ack_i && xact_nak_i;
    assign fail_g = running && !xact_ack_i && !xact_nak_i && xact_fail_i;
    assign pid_g = running && pid_err_i;
    assign bytes_sum = {1'b0, bytes_done_count_o}
        + {{(BYTES_W + 1 - async_desc_pkg::PKT_LEN_W){1'b0}}, xact_bytes_i};

    nak_err_counters u_counters (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .load_i(launch_ok),
        .err_init_i(err_count_init_i),
        .nak_init_i(nak_retry_count_init_i),
        .nak_reload_value_i(reload_q),
        .ack_i(ack_g),
        .nak_i(nak_g),
        .fail_i(fail_g && !pid_g),
        .err_count_o(err_count_o),
        .nak_retry_count_o(nak_retry_count_o),
        .nak_expired_o(nak_expired),
        .retry_exhausted_o(retry_exhausted)
    );

    // Descriptor fields: latched at launch, token may turn into PING
    always_comb
    begin
        reload_d = reload_q;
        req_d = req_q;
        mult_d = mult_q;
        split_d = split_o;
        kind_d = transfer_kind_o;
        token_d = token_code_o;
        faddr_d = target_function_addr_o;
        ep_d = target_endpoint_number_o;
        offset_d = payload_buffer_offset_o;
        cpu_addr_d = payload_cpu_addr_o;
        if (launch_ok)
        begin
            reload_d = nak_reload_value_i; // R6
            req_d = bytes_requested_count_i;
            mult_d = mult_i; // R19
            split_d = split_sel_i; // R12
            kind_d = transfer_kind_i; // R13
            token_d = token_code_i; // R14
            faddr_d = target_function_addr_i; // R15
            ep_d = {endpoint_hi_i, endpoint_lo_i}; // R16
            offset_d = payload_buffer_offset_i;
            // Processor address = base + word offset * 8
            cpu_addr_d = async_desc_pkg::PAYLOAD_CPU_BASE
                + {payload_buffer_offset_i, {async_desc_pkg::WORD_SHIFT{1'b0}}}; // R10
        end
        else if (running && ping_enter_i && token_code_o == async_desc_pkg::TOKEN_OUT)
        begin
            token_d = async_desc_pkg::TOKEN_PING; // R14
        end
    end

    // Field registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            reload_q <= 4'h0;
            req_q <= '0;
            mult_q <= 2'h0;
            split_o <= 1'b0;
            transfer_kind_o <= 2'h0;
            token_code_o <= 2'h0;
            target_function_addr_o <= 7'h00;
            target_endpoint_number_o <= 4'h0;
            payload_buffer_offset_o <= 16'h0000;
            payload_cpu_addr_o <= 20'h0_0000;
        end
        else
        begin
            reload_q <= reload_d;
            req_q <= req_d;
            mult_q <= mult_d;
            split_o <= split_d;
            transfer_kind_o <= kind_d;
            token_code_o <= token_d;
            target_function_addr_o <= faddr_d;
            target_endpoint_number_o <= ep_d;
            payload_buffer_offset_o <= offset_d;
            payload_cpu_addr_o <= cpu_addr_d;
        end
    end

    // Execution state, flags and byte progress. Terminations from the
    // counters arrive one cycle after the outcome, so they are checked first.
    always_comb
    begin
        state_d = state_q;
        valid_d = valid_o;
        active_d = active_o;
        xerr_d = xact_err_o;
        refused_d = 1'b0;
        done_d = 1'b0;
        exec_end_d = 1'b0;
        pkt_d = pkt_q;
        bytes_d = bytes_done_count_o;
        if (bytes_wr_i)
        begin
            bytes_d = bytes_wr_data_i; // R8
        end
        refused_d = launch_i && !launch_ok;
        // A refused launch must not swallow outcomes or terminations of a running one
        if (launch_ok)
        begin
            state_d = async_desc_pkg::ST_RUN;
            valid_d = 1'b1;
            active_d = 1'b1;
            xerr_d = 1'b0;
            pkt_d = 2'h0;
        end
        else if (state_q == async_desc_pkg::ST_RUN)
        begin
            if (nak_expired || retry_exhausted)
            begin
                // NAK exhaustion and a spent retry budget both end the descriptor
                state_d = async_desc_pkg::ST_HALT;
                valid_d = 1'b0; // R4 R17
                active_d = 1'b0;
            end
            else if (pid_g)
            begin
                state_d = async_desc_pkg::ST_HALT;
                xerr_d = 1'b1; // R18
                valid_d = 1'b0;
                active_d = 1'b0;
            end
            else if (ack_g)
            begin
                // Intermediate totals are kept between packets of one execution
                bytes_d = bytes_sum[BYTES_W-1:0]; // R8 R9
                if (bytes_sum >= {1'b0, req_q})
                begin
                    state_d = async_desc_pkg::ST_IDLE;
                    valid_d = 1'b0; // R17 R20
                    active_d = 1'b0;
                    done_d = 1'b1;
                end
                else if (pkt_q + 2'h1 == mult_q)
                begin
                    pkt_d = 2'h0;
                    exec_end_d = 1'b1; // R19
                end
                else
                begin
                    pkt_d = pkt_q + 2'h1;
                end
            end
        end
    end

    // State and flag registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= async_desc_pkg::ST_IDLE;
            valid_o <= 1'b0;
            active_o <= 1'b0;
            xact_err_o <= 1'b0;
            launch_refused_o <= 1'b0;
            done_o <= 1'b0;
            exec_end_o <= 1'b0;
            pkt_q <= 2'h0;
            bytes_done_count_o <= '0;
        end
        else
        begin
            state_q <= state_d;
            valid_o <= valid_d;
            active_o <= active_d;
            xact_err_o <= xerr_d;
            launch_refused_o <= refused_d;
            done_o <= done_d;
            exec_end_o <= exec_end_d;
            pkt_q <= pkt_d;
            bytes_done_count_o <= bytes_d;
        end
    end

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_nak_expiry_halts: assert property (nak_expired && !launch_i |=> !valid_o) // R4
        else $error("valid stayed set after NAK count expired");
    a_ack_reloads_nak: assert property (ack_g && !launch_i |=> nak_retry_count_o == $past(reload_q)) // R5
        else $error("NAK count not restored on acknowledge");
    a_reload_off_hold: assert property (nak_g && reload_q == async_desc_pkg::NAK_RELOAD_OFF
        && !launch_i |=> nak_retry_count_o == $past(nak_retry_count_o) && !nak_expired) // R6
        else $error("NAK count moved with reload zero");
    a_retry_decrement: assert property (fail_g && !pid_g && !launch_i
        && err_count_o != async_desc_pkg::ERR_NONE_LEFT
        |=> err_count_o == 2'($past(err_count_o) - 2'h1) && !retry_exhausted) // R1
        else $error("retry counter not decremented");
    a_retry_exhaust: assert property (fail_g && !pid_g && !launch_i
        && err_count_o == async_desc_pkg::ERR_NONE_LEFT |=> ##1 !valid_o && !active_o) // R17
        else $error("descriptor still valid after retries spent");
    a_pid_err_flags: assert property (pid_g && !launch_i && !nak_expired && !retry_exhausted
        |=> xact_err_o && !valid_o && !active_o) // R18
        else $error("PID error did not halt descriptor");
    a_launch_loads: assert property (launch_ok |=> nak_retry_count_o == $past(nak_retry_count_init_i)
        && err_count_o == $past(err_count_init_i) && valid_o && active_o) // R3
        else $error("launch did not load counters and flags");
    a_endpoint_join: assert property (launch_ok |=> target_endpoint_number_o
        == {$past(endpoint_hi_i), $past(endpoint_lo_i)}
        && target_function_addr_o == $past(target_function_addr_i)) // R15 R16
        else $error("target address or endpoint wrong");
    a_bytes_accumulate: assert property (ack_g && !launch_i && !bytes_wr_i && !nak_expired
        && !retry_exhausted && !pid_g |=> bytes_done_count_o
        == BYTES_W'($past(bytes_done_count_o) + $past(xact_bytes_i))) // R8
        else $error("byte progress not accumulated");
    a_done_complete: assert property (done_o |-> !valid_o && !active_o
        && bytes_done_count_o >= req_q) // R20
        else $error("completion without full byte count");
    a_refuse_undefined: assert property (launch_i && (mult_i == async_desc_pkg::MULT_UNDEFINED
        || token_code_i == async_desc_pkg::TOKEN_PING) |=> launch_refused_o && !$rose(active_o)) // R19
        else $error("malformed descriptor was launched");

    c_completion: cover property (launch_ok ##[1:40] done_o);
    c_nak_expiry: cover property (nak_g ##1 nak_expired ##1 !valid_o);
    c_pid_error: cover property (pid_g ##1 xact_err_o);
    c_exec_end: cover property (exec_end_o ##[1:20] done_o);
endmodule : async_desc_engine

// ### design/async_desc_pkg.sv
// Constants shared by the asynchronous descriptor engine and its counters.
// Assumes a single 40 MHz core clock and a synchronous active-high reset.
package async_desc_pkg;
    // Field widths of the upper descriptor words
    localparam int ERR_W = 2;
    localparam int NAK_W = 4;
    localparam int BYTES_W = 15;
    localparam int OFFSET_W = 16;
    localparam int ADDR_W = 7;
    localparam int EP_HI_W = 3;
    localparam int PKT_LEN_W = 11;
    localparam int CPU_ADDR_W = 20;
    // Field positions inside the 64-bit descriptor words, for software images
    localparam int ERR_LSB = 55;
    localparam int NAK_LSB = 51;
    localparam int BYTES_DONE_LSB = 32;
    localparam int RELOAD_LSB = 25;
    localparam int OFFSET_LSB = 8;
    localparam int SPLIT_BIT = 46;
    localparam int KIND_LSB = 44;
    localparam int TOKEN_LSB = 42;
    localparam int ADDR_LSB = 35;
    localparam int EP_HI_LSB = 32;
    // Encodings
    localparam logic [1:0] KIND_CONTROL = 2'h0;
    localparam logic [1:0] KIND_BULK = 2'h2;
    localparam logic [1:0] TOKEN_OUT = 2'h0;
    localparam logic [1:0] TOKEN_IN = 2'h1;
    localparam logic [1:0] TOKEN_SETUP = 2'h2;
    localparam logic [1:0] TOKEN_PING = 2'h3;
    localparam logic [1:0] MULT_UNDEFINED = 2'h0;
    localparam logic [1:0] ERR_NONE_LEFT = 2'h0;
    localparam logic [1:0] ERR_ONE = 2'h1;
    localparam logic [3:0] NAK_RELOAD_OFF = 4'h0;
    localparam logic [3:0] NAK_LAST = 4'h1;
    localparam logic [3:0] NAK_ZERO = 4'h0;
    localparam logic [14:0] BYTES_ZERO = 15'h0000;
    // Processor view of the payload buffer: base and word shift
    localparam logic [19:0] PAYLOAD_CPU_BASE = 20'h0_0400;
    localparam int WORD_SHIFT = 3;
    // Descriptor execution states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } desc_state_t;
endpackage : async_desc_pkg

// ### design/nak_err_counters.sv
// Retry-error and NAK counters of one asynchronous descriptor.
// Assumes the parent gates events so that at most one arrives per cycle.
`timescale 1ns/100ps
module nak_err_counters (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [1:0] err_init_i,
    input wire logic [3:0] nak_init_i,
    input wire logic [3:0] nak_reload_value_i,
    input wire logic ack_i,
    input wire logic nak_i,
    input wire logic fail_i,
    output logic [1:0] err_count_o,
    output logic [3:0] nak_retry_count_o,
    output logic nak_expired_o,
    output logic retry_exhausted_o
);
    logic [1:0] err_d;
    logic [3:0] nak_d;
    logic expired_d;
    logic exhausted_d;

    // Next counter values; launch load beats any event in the same cycle
    always_comb
    begin
        err_d = err_count_o;
        nak_d = nak_retry_count_o;
        expired_d = 1'b0;
        exhausted_d = 1'b0;
        if (load_i)
        begin
            err_d = err_init_i; // R1
            nak_d = nak_init_i; // R3
        end
        else if (ack_i)
        begin
            nak_d = nak_reload_value_i; // R5
        end
        else if (nak_i && nak_reload_value_i != async_desc_pkg::NAK_RELOAD_OFF) // R6
        begin
            // A counter already at zero still expires rather than wrapping
            if (nak_retry_count_o <= async_desc_pkg::NAK_LAST)
            begin
                nak_d = async_desc_pkg::NAK_ZERO;
                expired_d = 1'b1; // R4
            end
            else
            begin
                nak_d = nak_retry_count_o - async_desc_pkg::NAK_LAST; // R3
            end
        end
        else if (fail_i)
        begin
            if (err_count_o == async_desc_pkg::ERR_NONE_LEFT)
            begin
                exhausted_d = 1'b1; // R1
            end
            else
            begin
                err_d = err_count_o - async_desc_pkg::ERR_ONE; // R1
            end
        end
    end

    // Counter registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            err_count_o <= 2'h0;
            nak_retry_count_o <= 4'h0;
            nak_expired_o <= 1'b0;
            retry_exhausted_o <= 1'b0;
        end
        else
        begin
            err_count_o <= err_d;
            nak_retry_count_o <= nak_d;
            nak_expired_o <= expired_d;
            retry_exhausted_o <= exhausted_d;
        end
    end
endmodule : nak_err_counters

// ### sim/tb_async_transfer_descriptor_fields.sv
// Self-checking bench for the asynchronous descriptor engine.
// Assumes the endpoint model in usb_func_model.sv and a 40 MHz clock.
`timescale 1ns/100ps
module tb_async_transfer_descriptor_fields;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic launch_i, split_sel_i, endpoint_lo_i, bytes_wr_i, ping_enter_i, req;
    logic [1:0] err_init, kind, token, mult, rkind, kd, tk, err_cnt, kind_o, token_o;
    logic [3:0] nak_init, reload, rdelay, nak_cnt, ep_o;
    logic [14:0] req_bytes, wr_data, bytes_done;
    logic [15:0] offset, offset_o;
    logic [6:0] faddr, faddr_o;
    logic [2:0] ep_hi;
    logic [10:0] rbytes, xbytes, b1;
    logic ack, nak, fail, pid, valid, active, xerr, refused, done, exec_end, split_o;
    logic [19:0] cpu_addr;
    logic [5:0] bad_tab [4] = '{6'h00, 6'h14, 6'h1c, 6'h13}; // {mult, kind, token}
    int errors, cmp_count, seed;

    async_desc_engine uut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .launch_i(launch_i),
        .err_count_init_i(err_init), .nak_retry_count_init_i(nak_init),
        .nak_reload_value_i(reload), .bytes_requested_count_i(req_bytes),
        .payload_buffer_offset_i(offset), .split_sel_i(split_sel_i),
        .transfer_kind_i(kind), .token_code_i(token), .target_function_addr_i(faddr),
        .endpoint_hi_i(ep_hi), .endpoint_lo_i(endpoint_lo_i), .mult_i(mult),
        .bytes_wr_i(bytes_wr_i), .bytes_wr_data_i(wr_data), .ping_enter_i(ping_enter_i),
        .xact_ack_i(ack), .xact_bytes_i(xbytes), .xact_nak_i(nak), .xact_fail_i(fail),
        .pid_err_i(pid), .valid_o(valid), .active_o(active), .xact_err_o(xerr),
        .launch_refused_o(refused), .done_o(done), .exec_end_o(exec_end),
        .err_count_o(err_cnt), .nak_retry_count_o(nak_cnt), .bytes_done_count_o(bytes_done),
        .split_o(split_o), .transfer_kind_o(kind_o), .token_code_o(token_o),
        .target_function_addr_o(faddr_o), .target_endpoint_number_o(ep_o),
        .payload_buffer_offset_o(offset_o), .payload_cpu_addr_o(cpu_addr)
    );

    usb_func_model far_end (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req), .kind_i(rkind),
        .bytes_i(rbytes), .delay_i(rdelay), .ack_o(ack), .nak_o(nak), .fail_o(fail),
        .pid_err_o(pid), .bytes_o(xbytes)
    );

    // 25 ns period
    initial forever #12.5 clock_i = ~clock_i;

    // Processor address of a payload word offset
    function automatic logic [19:0] exp_cpu(input logic [15:0] off);
        return 20'h0_0400 + {1'b0, off, 3'h0};
    endfunction : exp_cpu

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // Present a descriptor for one cycle; reserved bits have no port, so stay zero
    task automatic launch(input logic [1:0] e, input logic [3:0] n, input logic [3:0] rl,
        input logic [14:0] rb, input logic [1:0] m, input logic [1:0] k, input logic [1:0] t);
        // Let an edge pass so back-to-back launches never retoggle launch_i in one step
        @(posedge clock_i);
        #1 err_init = e;
        nak_init = n;
        reload = rl;
        req_bytes = rb;
        mult = m;
        kind = k;
        token = t;
        offset = 16'($random(seed));
        faddr = 7'($random(seed));
        ep_hi = 3'($random(seed));
        endpoint_lo_i = 1'($random(seed));
        split_sel_i = 1'($random(seed));
        launch_i = 1'b1;
        @(posedge clock_i);
        #1 launch_i = 1'b0;
    endtask : launch

    // Ask the endpoint for one outcome; return just after the edge on which the engine took it
    task automatic outcome(input logic [1:0] k, input logic [10:0] b);
        int n;
        n = 0;
        rkind = k;
        rbytes = b;
        rdelay = {1'b0, 3'($random(seed))};
        req = 1'b1;
        @(posedge clock_i);
        #1 req = 1'b0;
        while (!(ack || nak || fail || pid) && n < 40)
        begin
            @(posedge clock_i);
            #1 n++;
        end
        if (n >= 40)
        begin
            errors++;
            wrap_up();
        end
        @(posedge clock_i);
        #1;
    endtask : outcome

    initial
    begin
        seed = 88841;
        errors = 0;
        cmp_count = 0;
        {launch_i, split_sel_i, endpoint_lo_i, bytes_wr_i, ping_enter_i, req} = 6'h00;
        {err_init, kind, token, mult, rkind} = 10'h000;
        {nak_init, reload, rdelay} = 12'h000;
        {req_bytes, wr_data, offset, faddr, ep_hi, rbytes} = '0;
        repeat (20) @(posedge clock_i);
        #1 sys_rst_i = 1'b0;
        chk(valid, 1'b0);
        chk(bytes_done, 15'h0000);
        // Random descriptors: every field must reach its output unchanged
        repeat (12)
        begin
            kd = {1'($random(seed)), 1'b0};
            tk = 2'($random(seed));
            if (tk == 2'h3)
                tk = 2'h1;
            launch(2'h3, 4'h2, 4'h2, 15'h7fff, 2'h1, kd, tk);
            chk(valid, 1'b1);
            chk(err_cnt, 2'h3);
            chk(nak_cnt, 4'h2);
            chk(split_o, split_sel_i);
            chk(kind_o, kd);
            chk(token_o, tk);
            chk(faddr_o, faddr);
            chk(ep_o, {ep_hi, endpoint_lo_i});
            chk(offset_o, offset);
            chk(cpu_addr, exp_cpu(offset));
        end
        // OUT descriptor turned to PING, then a software byte write
        launch(2'h3, 4'h2, 4'h2, 15'h7fff, 2'h1, 2'h2, 2'h0);
        ping_enter_i = 1'b1;
        @(posedge clock_i);
        #1 ping_enter_i = 1'b0;
        chk(token_o, 2'h3);
        wr_data = 15'($random(seed));
        bytes_wr_i = 1'b1;
        @(posedge clock_i);
        #1 chk(bytes_done, wr_data);
        // Launch does not clear progress, so software zeroes it for the next descriptor
        wr_data = 15'h0000;
        @(posedge clock_i);
        #1 bytes_wr_i = 1'b0;
        chk(bytes_done, 15'h0000);
        // A NAK, then two packets: reload on ack, completion at the sum
        b1 = 11'($random(seed)) & 11'h3ff | 11'h001;
        launch(2'h3, 4'h3, 4'h3, 15'({b1, 1'b0}), 2'h2, 2'h2, 2'h1);
        outcome(2'h1, 11'h000);
        chk(nak_cnt, 4'h2);
        outcome(2'h0, b1);
        chk(nak_cnt, 4'h3);
        chk(bytes_done, 15'(b1));
        chk(done, 1'b0);
        outcome(2'h0, b1);
        chk(done, 1'b1);
        chk(bytes_done, 15'({b1, 1'b0}));
        chk(valid, 1'b0);
        chk(active, 1'b0);
        // One packet per execution, not complete
        launch(2'h3, 4'h1, 4'h1, 15'h7fff, 2'h1, 2'h2, 2'h1);
        outcome(2'h0, b1);
        chk(exec_end, 1'b1);
        // NAK count runs out with a nonzero reload
        launch(2'h3, 4'h2, 4'h2, 15'h7fff, 2'h1, 2'h0, 2'h2);
        outcome(2'h1, 11'h000);
        chk(valid, 1'b1);
        outcome(2'h1, 11'h000);
        chk(nak_cnt, 4'h0);
        @(posedge clock_i);
        #1 chk(valid, 1'b0);
        // Zero reload: NAKs never end the descriptor, even from a zero count
        launch(2'h3, 4'h0, 4'h0, 15'h7fff, 2'h1, 2'h2, 2'h1);
        repeat (3) outcome(2'h1, 11'h000);
        chk(nak_cnt, 4'h0);
        @(posedge clock_i);
        #1 chk(valid, 1'b1);
        // Every retry budget: count down, then one more failure halts
        for (int e = 0; e < 4; e++)
        begin
            launch(2'(e), 4'h0, 4'h0, 15'h7fff, 2'h1, 2'h2, 2'h0);
            for (int i = e; i > 0; i--)
            begin
                outcome(2'h2, 11'h000);
                chk(err_cnt, {30'h0, 2'(i - 1)});
                chk(valid, 1'b1);
            end
            outcome(2'h2, 11'h000);
            @(posedge clock_i);
            #1 chk(valid, 1'b0);
        end
        // PID error, then refused launches must leave the halted state alone
        launch(2'h3, 4'h2, 4'h2, 15'h7fff, 2'h1, 2'h0, 2'h2);
        outcome(2'h3, 11'h000);
        chk(xerr, 1'b1);
        chk(valid, 1'b0);
        chk(active, 1'b0);
        for (int r = 0; r < 4; r++)
        begin
            launch(2'h3, 4'h2, 4'h2, 15'h7fff, bad_tab[r][5:4], bad_tab[r][3:2], bad_tab[r][1:0]);
            chk(refused, 1'b1);
            chk(valid, 1'b0);
            chk(xerr, 1'b1);
        end
        wrap_up();
    end
endmodule : tb_async_transfer_descriptor_fields

// ### sim/usb_func_model.sv
// Behavioural USB function endpoint that answers each transaction attempt.
// Assumes one request at a time, sampled on the rising edge of clock_i.
`timescale 1ns/100ps
module usb_func_model (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic req_i,
    input wire logic [1:0] kind_i,
    input wire logic [10:0] bytes_i,
    input wire logic [3:0] delay_i,
    output logic ack_o,
    output logic nak_o,
    output logic fail_o,
    output logic pid_err_o,
    output logic [10:0] bytes_o
);
    logic pend_q;
    logic [3:0] cnt_q;
    logic [1:0] kind_q;
    logic [10:0] len_q;

    // Answer after a chosen wait, promptly or slowly; outcomes are one-cycle pulses
    always_ff @(posedge clock_i)
    begin
        {ack_o, nak_o, fail_o, pid_err_o} <= 4'h0;
        bytes_o <= ~bytes_o; // Released byte count keeps changing, never holds stale data
        if (sys_rst_i)
        begin
            pend_q <= 1'b0;
            bytes_o <= 11'h2aa;
        end
        else if (req_i)
        begin
            pend_q <= 1'b1;
            cnt_q <= delay_i;
            kind_q <= kind_i;
            len_q <= bytes_i;
        end
        else if (pend_q && cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        else if (pend_q)
        begin
            pend_q <= 1'b0;
            ack_o <= (kind_q == 2'h0);
            nak_o <= (kind_q == 2'h1);
            fail_o <= (kind_q == 2'h2);
            pid_err_o <= (kind_q == 2'h3);
            if (kind_q == 2'h0)
                bytes_o <= len_q; // Byte count travels only with the acknowledge
        end
    end
endmodule : usb_func_model
